// ### verilog/tis_tap.sv
// Test access port controller with instruction register and two test data registers.
// Assumes the tester's clock is far slower than clk_in; all test pins are sampled here.
// Functional notes
// - Pause-IR holds while select is low.
// - Pause-IR with select high goes Exit2-IR.
// - Pause-IR freezes shifting, data and instruction.
// - Exit2-IR with select high goes Update-IR.
// - Exit2-IR with select low returns Shift-IR.
// - Exit2-IR lasts one cycle, registers hold.
// - Update-IR latches instruction on falling clock.
// - Latched instruction selects the data register.
// - Update-IR leaves selected data registers unchanged.
// - Shift-IR moves instruction bits toward output.
// - Capture-IR loads fixed pattern one-zero-zero.
`timescale 1ns/1ps
module tis_tap (
    input  wire logic                     clk_in,
    input  wire logic                     rst_n_in,
    input  wire logic                     tck_in,
    input  wire logic                     tms_in,
    input  wire logic                     tdi_in,
    input  wire logic                     trst_n_in,
    output logic                          tdo_out,
    output logic                          tdo_oe_out,
    output logic [tis_pkg::IR_W-1:0]      ir_out,
    output logic                          bypass_sel_out,
    output tis_pkg::tis_state_t           state_out
);
    tis_pkg::tis_pins_t  pins_raw;   // Raw pin group.
    tis_pkg::tis_pins_t  pins;       // Pin group after two flip-flops.
    logic                tck_d;      // Synchronised clock one cycle late.
    logic                tck_rise;   // Rising edge of the test clock.
    logic                tck_fall;   // Falling edge of the test clock.
    tis_pkg::tis_state_t st;         // Controller state.
    tis_pkg::tis_state_t next_st;    // Controller state after the next rising edge.
    logic [tis_pkg::IR_W-1:0] ir_sh; // Instruction shift stages.
    logic [tis_pkg::DR_W-1:0] dr;    // General test data register.
    logic                bypass;     // One-bit bypass register.

    assign pins_raw = '{tck: tck_in, tms: tms_in, tdi: tdi_in, trst_n: trst_n_in};

    // All four pins come from the tester's domain and share one synchroniser.
    // The stages reset to zero, so the test reset reads active for two cycles after a
    // system reset; that only holds the controller where the system reset put it anyway.
    tis_sync #(
        .W($bits(tis_pkg::tis_pins_t))
    ) u_sync (
        .clk_in  (clk_in),
        .rst_n_in(rst_n_in),
        .d_in    (pins_raw),
        .q_out   (pins)
    );

    // Edge finder; select and data were synchronised alongside, so they line up.
    // Clearing tck_d to the idle low level of the pin avoids a false edge after reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tck_d <= 1'b0;
        end else begin
            tck_d <= pins.tck;
        end
    end
    assign tck_rise = pins.tck & ~tck_d;
    assign tck_fall = ~pins.tck & tck_d;

    // Keeping the whole state walk, not just the tail, lets a tester reach the tail legally.
    // Next-state table of the controller, steered by the select pin.
    always_comb begin
        next_st = st;
        unique case (st)
            tis_pkg::TLR:      next_st = pins.tms ? tis_pkg::TLR      : tis_pkg::RTI;
            tis_pkg::RTI:      next_st = pins.tms ? tis_pkg::SEL_DR   : tis_pkg::RTI;
            tis_pkg::SEL_DR:   next_st = pins.tms ? tis_pkg::SEL_IR   : tis_pkg::CAP_DR;
            tis_pkg::CAP_DR:   next_st = pins.tms ? tis_pkg::EXIT1_DR : tis_pkg::SHIFT_DR;
            tis_pkg::SHIFT_DR: next_st = pins.tms ? tis_pkg::EXIT1_DR : tis_pkg::SHIFT_DR;
            tis_pkg::EXIT1_DR: next_st = pins.tms ? tis_pkg::UPD_DR   : tis_pkg::PAUSE_DR;
            tis_pkg::PAUSE_DR: next_st = pins.tms ? tis_pkg::EXIT2_DR : tis_pkg::PAUSE_DR;
            tis_pkg::EXIT2_DR: next_st = pins.tms ? tis_pkg::UPD_DR   : tis_pkg::SHIFT_DR;
            tis_pkg::UPD_DR:   next_st = pins.tms ? tis_pkg::SEL_DR   : tis_pkg::RTI;
            tis_pkg::SEL_IR:   next_st = pins.tms ? tis_pkg::TLR      : tis_pkg::CAP_IR;
            tis_pkg::CAP_IR:   next_st = pins.tms ? tis_pkg::EXIT1_IR : tis_pkg::SHIFT_IR;
            tis_pkg::SHIFT_IR: next_st = pins.tms ? tis_pkg::EXIT1_IR : tis_pkg::SHIFT_IR;
            tis_pkg::EXIT1_IR: next_st = pins.tms ? tis_pkg::UPD_IR   : tis_pkg::PAUSE_IR;
            // Pause holds on low select and leaves for the second exit on high.
            tis_pkg::PAUSE_IR: next_st = pins.tms ? tis_pkg::EXIT2_IR : tis_pkg::PAUSE_IR;
            // The second exit either ends the scan or resumes shifting.
            tis_pkg::EXIT2_IR: next_st = pins.tms ? tis_pkg::UPD_IR   : tis_pkg::SHIFT_IR;
            tis_pkg::UPD_IR:   next_st = pins.tms ? tis_pkg::SEL_DR   : tis_pkg::RTI;
        endcase
    end

    // State register moves only on a rising test clock; a low test reset forces reset state.
    // The test reset passes the synchroniser, so it acts within three clk_in cycles, not at once.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= tis_pkg::TLR;
        end else if (!pins.trst_n) begin
            st <= tis_pkg::TLR;
        end else if (tck_rise) begin
            st <= next_st;
        end
    end
    assign state_out = st;

    // Instruction shift stages: capture the fixed pattern, then shift toward the output.
    // Every other state, pause and second exit among them, leaves the stages untouched.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ir_sh <= tis_pkg::IR_RESET;
        end else if (tck_rise && st == tis_pkg::CAP_IR) begin
            ir_sh <= tis_pkg::IR_CAPTURE;
        end else if (tck_rise && st == tis_pkg::SHIFT_IR) begin
            ir_sh <= {pins.tdi, ir_sh[tis_pkg::IR_W-1:1]};
        end
    end

    // Current instruction: changes on the falling edge inside the update state, and reloads the reset code in test logic reset.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            ir_out <= tis_pkg::IR_RESET;
        end else if (st == tis_pkg::TLR) begin
            ir_out <= tis_pkg::IR_RESET;
        end else if (tck_fall && st == tis_pkg::UPD_IR) begin
            ir_out <= ir_sh;
        end
    end

    // Register selection follows the current instruction one cycle later.
    // The lag is harmless: no data register moves until a test clock edge many cycles later.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bypass_sel_out <= 1'b1;
        end else begin
            bypass_sel_out <= (ir_out == tis_pkg::IR_BYPASS);
        end
    end

    // Bypass bit clears at capture and shifts only in the data shift state.
    // Its value only matters while it is selected; otherwise it simply idles.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            bypass <= 1'b0;
        end else if (tck_rise && bypass_sel_out && st == tis_pkg::CAP_DR) begin
            bypass <= 1'b0;
        end else if (tck_rise && bypass_sel_out && st == tis_pkg::SHIFT_DR) begin
            bypass <= pins.tdi;
        end
    end

    // The general data register has no parallel input, so it moves only while shifting.
    // With no capture, its content is whatever was last scanned in, or zero after reset.
    // Pause, exit and update states of either scan leave it alone.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            dr <= tis_pkg::DR_RESET;
        end else if (tck_rise && !bypass_sel_out && st == tis_pkg::SHIFT_DR) begin
            dr <= {pins.tdi, dr[tis_pkg::DR_W-1:1]};
        end
    end

    // Serial output changes on the falling edge so the tester sees it stable at the rise.
    // Outside a shift state the bit means nothing, but it is still driven to a known value.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_out <= (st == tis_pkg::SHIFT_IR) || (st == tis_pkg::SHIFT_DR);
            if (st == tis_pkg::SHIFT_IR) begin
                tdo_out <= ir_sh[0];
            end else if (bypass_sel_out) begin
                tdo_out <= bypass;
            end else begin
                tdo_out <= dr[0];
            end
        end
    end

    // Checks run on the system clock and rest while either reset is active.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in || !pins.trst_n);

    // A detected rise together with the select level that travelled with it.
    sequence s_rise_low;
        tck_rise && !pins.tms;
    endsequence
    sequence s_rise_high;
        tck_rise && pins.tms;
    endsequence

    AST_PAUSE_HOLD: assert property ((st == tis_pkg::PAUSE_IR) ##0 s_rise_low |=>
        st == tis_pkg::PAUSE_IR) else $error("Pause left on low select.");
    AST_PAUSE_EXIT: assert property ((st == tis_pkg::PAUSE_IR) ##0 s_rise_high |=>
        st == tis_pkg::EXIT2_IR) else $error("Pause did not reach second exit.");
    AST_PAUSE_FROZEN: assert property (st == tis_pkg::PAUSE_IR |=>
        $stable(ir_sh) && $stable(dr) && $stable(ir_out)) else $error("Pause changed a register.");
    AST_EXIT2_UPD: assert property ((st == tis_pkg::EXIT2_IR) ##0 s_rise_high |=>
        st == tis_pkg::UPD_IR) else $error("Second exit did not reach update.");
    AST_EXIT2_SHIFT: assert property ((st == tis_pkg::EXIT2_IR) ##0 s_rise_low |=>
        st == tis_pkg::SHIFT_IR) else $error("Second exit did not resume shift.");
    AST_EXIT2_ONCE: assert property ((st == tis_pkg::EXIT2_IR) ##0 tck_rise |=>
        st != tis_pkg::EXIT2_IR && $stable(ir_out) && $stable(dr)) else $error("Second exit overstayed.");
    AST_UPD_LATCH: assert property ((st == tis_pkg::UPD_IR) && tck_fall |=>
        ir_out == $past(ir_sh)) else $error("Update did not latch instruction.");
    AST_SELECT: assert property ($changed(ir_out) |=>
        bypass_sel_out == (ir_out == tis_pkg::IR_BYPASS)) else $error("Selection missed instruction.");
    AST_UPD_DR_HOLD: assert property (st == tis_pkg::UPD_IR |=>
        $stable(dr) && $stable(bypass)) else $error("Update disturbed data register.");
    AST_IR_SHIFT: assert property ((st == tis_pkg::SHIFT_IR) && tck_rise |=>
        ir_sh == {$past(pins.tdi), $past(ir_sh[tis_pkg::IR_W-1:1])}) else $error("Bad shift.");
    AST_CAPTURE: assert property ((st == tis_pkg::CAP_IR) && tck_rise |=>
        ir_sh == tis_pkg::IR_CAPTURE) else $error("Capture pattern wrong.");
    AST_STATE_EDGE: assert property (!tck_rise |=> $stable(st))
        else $error("State moved without rising test clock.");
    // The output enable follows the state seen at each falling test clock.
    AST_OE_SHIFT: assert property (tck_fall |=>
        tdo_oe_out == ($past(st) == tis_pkg::SHIFT_IR || $past(st) == tis_pkg::SHIFT_DR))
        else $error("Output enable wrong after falling test clock.");
    // Outside update and test logic reset the current instruction never moves.
    AST_IR_ONLY_UPD: assert property ($changed(ir_out) |->
        $past(st) == tis_pkg::UPD_IR || $past(st) == tis_pkg::TLR)
        else $error("Instruction changed outside update.");

endmodule

// ### verilog/tis_pkg.sv
// Shared types and constants for the instruction-scan tail of the test access port.
// Assumes every user writes tis_pkg::name; nothing is imported.
package tis_pkg;

    // Width of the instruction register.
    localparam int IR_W = 3;
    // Width of the general test data register.
    localparam int DR_W = 8;
    // Fixed pattern loaded into the instruction shift stages at capture.
    localparam logic [IR_W-1:0] IR_CAPTURE = 3'h4;
    // Instruction held after test logic reset; all ones selects the bypass bit.
    localparam logic [IR_W-1:0] IR_RESET   = 3'h7;
    // Instruction code that selects the one-bit bypass register.
    localparam logic [IR_W-1:0] IR_BYPASS  = 3'h7;
    // Reset value of the general test data register.
    localparam logic [DR_W-1:0] DR_RESET   = 8'h00;
    // Number of flip-flops in each pin synchroniser.
    localparam int SYNC_STAGES = 2;

    // Controller states.
    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } tis_state_t;

    // Test pins as one group, raw or synchronised.
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
        logic trst_n;
    } tis_pins_t;

endpackage

// ### verilog/tis_sync.sv
// Two-stage synchroniser for a group of slow external pins.
// Assumes the pins are asynchronous to clk_in and change far slower than it.
`timescale 1ns/1ps
module tis_sync #(
    parameter int W = 4
) (
    input  wire logic         clk_in,
    input  wire logic         rst_n_in,
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] q_out
);
    logic [W-1:0] meta; // First stage, read only by the second stage.

    // The first stage may go metastable; only q_out is safe to use.
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta  <= '0;
            q_out <= '0;
        end else begin
            meta  <= d_in;
            q_out <= meta;
        end
    end
endmodule

// ### testbench/tis_tester.sv
// Behavioural boundary-scan tester that drives the clock, select and data pins of the access port.
// Assumes the bench calls step; pins only change on falling edges of clk_in.
`timescale 1ns/1ps
module tis_tester (
    input  wire logic clk_in,
    input  wire logic tdo_in,
    input  wire logic tdo_oe_in,
    output logic      tck_out,
    output logic      tms_out,
    output logic      tdi_out
);
    // The test clock stands low between frames, as a real tester leaves it.
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b0;
    end
    // One 160 ns test clock period; pins are set 70 ns before the rise and held after it.
    task automatic step(input logic tms, input logic tdi, output logic tdo_seen);
        @(negedge clk_in);
        tms_out = tms;
        tdi_out = tdi;
        repeat (7) @(negedge clk_in);
        // A released output reads as the inverse of its last value, so a stale bit shows.
        tdo_seen = tdo_oe_in ? tdo_in : ~tdo_in;
        tck_out = 1'b1;
        repeat (8) @(negedge clk_in);
        tck_out = 1'b0;
        // The data bit is spent, so it flips rather than look valid by accident.
        tdi_out = ~tdi;
    endtask
endmodule

// ### testbench/tb_tis_tap.sv
// Self-checking bench for the instruction-scan tail of the test access port.
// Assumes tis_tester drives the clock, select and data pins, the bench drives trst_n; the system clock runs at 100 MHz.
`timescale 1ns/1ps
module tb_tis_tap;
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     trst_n = 1'b1;
    logic                     tck;
    logic                     tms;
    logic                     tdi;
    logic                     tdo;
    logic                     tdo_oe;
    logic                     sel;
    logic                     seen;
    logic [tis_pkg::IR_W-1:0] ir;
    tis_pkg::tis_state_t      state;
    int                       failures = 0;
    int                       tests_run = 0;

    // Free-running system clock.
    always #5 clk = ~clk;

    tis_tester tester_u (.clk_in(clk), .tdo_in(tdo), .tdo_oe_in(tdo_oe), .tck_out(tck),
        .tms_out(tms), .tdi_out(tdi));

    tis_tap dut_u (.clk_in(clk), .rst_n_in(rst_n), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
        .trst_n_in(trst_n), .tdo_out(tdo), .tdo_oe_out(tdo_oe), .ir_out(ir),
        .bypass_sel_out(sel), .state_out(state));

    // Prints the counts and the verdict, then stops the run.
    task automatic end_sim();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk_state(input tis_pkg::tis_state_t exp);
        tests_run++;
        if (state !== exp) begin
            failures++;
            $display("wrong value state expected %0h seen %0h", exp, state);
        end
    endtask

    task automatic chk_ir(input logic [tis_pkg::IR_W-1:0] exp);
        tests_run++;
        if (ir !== exp) begin
            failures++;
            $display("wrong value instruction expected %0h seen %0h", exp, ir);
        end
    endtask

    task automatic chk_bit(input string what, input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", what, exp, got);
        end
    endtask

    // One test clock period with the given select and data bits.
    task automatic go(input logic m, input logic d);
        tester_u.step(m, d, seen);
    endtask

    // Walks to capture and shifts in 3'h5; the capture pattern comes out first.
    task automatic scan_first();
        go(1'b0, 1'b0);
        go(1'b1, 1'b0);
        go(1'b1, 1'b0);
        go(1'b0, 1'b0);
        chk_state(tis_pkg::CAP_IR);
        go(1'b0, 1'b0);
        chk_state(tis_pkg::SHIFT_IR);
        go(1'b0, 1'b1);
        chk_bit("tdo", seen, 1'b0);
        chk_bit("tdo enable", tdo_oe, 1'b1);
        go(1'b0, 1'b0);
        chk_bit("tdo", seen, 1'b0);
        go(1'b1, 1'b1);
        chk_bit("tdo", seen, 1'b1);
        go(1'b0, 1'b0);
        chk_state(tis_pkg::PAUSE_IR);
    endtask

    // Holds in pause, then leaves through the second exit back to shifting.
    task automatic pause_and_return();
        repeat (3) begin
            go(1'b0, 1'b1);
            chk_state(tis_pkg::PAUSE_IR);
            chk_ir(tis_pkg::IR_RESET);
            chk_bit("tdo enable", tdo_oe, 1'b0);
        end
        go(1'b1, 1'b0);
        chk_state(tis_pkg::EXIT2_IR);
        chk_ir(tis_pkg::IR_RESET);
        go(1'b0, 1'b0);
        chk_state(tis_pkg::SHIFT_IR);
    endtask

    // Shifts in 3'h2; the bits of 3'h5 must emerge unharmed by the pause.
    task automatic scan_second();
        go(1'b0, 1'b0);
        chk_bit("tdo", seen, 1'b1);
        go(1'b0, 1'b1);
        chk_bit("tdo", seen, 1'b0);
        go(1'b1, 1'b0);
        chk_bit("tdo", seen, 1'b1);
        go(1'b0, 1'b0);
        go(1'b1, 1'b0);
        chk_state(tis_pkg::EXIT2_IR);
    endtask

    // The new code must not appear at the rising edge, only after the fall.
    task automatic update_instr();
        go(1'b1, 1'b0);
        chk_state(tis_pkg::UPD_IR);
        chk_ir(tis_pkg::IR_RESET);
        repeat (8) @(negedge clk);
        chk_ir(3'h2);
        chk_bit("bypass select", sel, 1'b0);
        go(1'b0, 1'b0);
        chk_state(tis_pkg::RTI);
        chk_ir(3'h2);
    endtask

    // Test reset returns the controller and the instruction to their reset values.
    task automatic test_reset();
        trst_n = 1'b0;
        repeat (6) @(negedge clk);
        trst_n = 1'b1;
        chk_state(tis_pkg::TLR);
        chk_ir(tis_pkg::IR_RESET);
        chk_bit("bypass select", sel, 1'b1);
    endtask

    // Main sequence: reset for ten cycles, then the scenarios in order.
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        chk_state(tis_pkg::TLR);
        scan_first();
        pause_and_return();
        scan_second();
        update_instr();
        test_reset();
        end_sim();
    end

    // The scenarios need about 3.6 us; a hang is cut off well beyond that.
    initial begin
        #100000;
        failures++;
        end_sim();
    end
endmodule
